// >>> tb.sv
// Self-checking testbench for the compare and PWM timer.
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   typedef struct {logic [7:0] addr; logic [31:0] data;} tmoc_row_type;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, overflow_irq;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [5:0]       ch_pin_out, ch_pin_oe, channel_irq;
   logic [5:0][15:0] high_cnt, period;
   int               num_errors, cmp_count, cycles, n;
   tmoc_row_type     rows[8];

   tmoc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
      .overflow_irq(overflow_irq), .channel_irq(channel_irq));
   tmoc_pin_load load_u (.pclk(pclk), .pin(ch_pin_out), .oe(ch_pin_oe),
      .high_cnt(high_cnt), .period(period));

   // Clock of 10 ns period.
   always #5 pclk = ~pclk;

   // Cycle ceiling that cuts a hang short.
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         stop_test();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One APB transfer; read data lands in rd at the answering edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the cycle ceiling ends a wait that never sees ready.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rows = '{'{8'h00, 32'h20}, '{8'h04, 32'h0}, '{8'h08, 32'hffff}, '{8'h0c, 32'h0},
               '{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h3c, 32'h0}, '{8'h01, 32'h0}};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Writes to the unmapped and read-only places must leave no trace.
      apb(1'b1, 8'h0c, 32'h0000_00ff);
      apb(1'b1, 8'h04, 32'h0000_1234);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].addr, 32'h0);
         `CHK(rd, rows[i].data)
      end
      // Period 256, pin 0 clears at 128, pin 1 full duty, pins 2 and 3 linked.
      apb(1'b1, 8'h08, 32'h0000_00ff);
      apb(1'b1, 8'h14, 32'h0000_0080);
      apb(1'b1, 8'h10, 32'h0000_005a);
      apb(1'b1, 8'h18, 32'h0000_005b);
      apb(1'b1, 8'h24, 32'h0000_0040);
      apb(1'b1, 8'h20, 32'h0000_002a);
      apb(1'b1, 8'h28, 32'h0000_000c);
      apb(1'b1, 8'h00, 32'h0000_0050);
      `CHK(ch_pin_oe, 6'b000111)
      repeat (768) @(posedge pclk);
      `CHK(period[0], 16'd256)
      `CHK(high_cnt[0], 16'd128)
      `CHK(ch_pin_out[1], 1'b1)
      `CHK(high_cnt[2], 16'd64)
      apb(1'b1, 8'h2c, 32'h0000_0020);
      repeat (768) @(posedge pclk);
      `CHK(high_cnt[2], 16'd32)
      `CHK(period[2], 16'd256)
      `CHK(ch_pin_out[1], 1'b1)
      apb(1'b1, 8'h24, 32'h0000_0060);
      repeat (768) @(posedge pclk);
      `CHK(high_cnt[2], 16'd96)
      `CHK(ch_pin_oe[3], 1'b0)
      // Flags are set, read back, then cleared by writing zero.
      `CHK(overflow_irq, 1'b1)
      `CHK(channel_irq[0], 1'b1)
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd[7], 1'b1)
      apb(1'b0, 8'h10, 32'h0);
      `CHK(rd[7], 1'b1)
      apb(1'b1, 8'h00, 32'h0000_0048);
      `CHK(overflow_irq, 1'b0)
      n = 0;
      while (overflow_irq !== 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      `CHK(overflow_irq, 1'b1)
      // The overflow handler raises the width of pin 0 from 128 to 144.
      apb(1'b1, 8'h14, 32'h0000_0090);
      apb(1'b1, 8'h10, 32'h0000_005a);
      `CHK(channel_irq[0], 1'b0)
      n = 0;
      while (channel_irq[0] !== 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      `CHK(n inside {[126:146]}, 1'b1)
      // The compare handler lowers the width back to 128 for the next period.
      apb(1'b1, 8'h14, 32'h0000_0080);
      repeat (200) @(posedge pclk);
      `CHK(high_cnt[0], 16'd144)
      repeat (256) @(posedge pclk);
      `CHK(high_cnt[0], 16'd128)
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd[15:8], 8'h00)
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h0000_00c0)
      // A reset in mid-run drops pins, enables and requests and stops the counter.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK({ch_pin_out, ch_pin_oe, channel_irq, overflow_irq}, 19'h00000)
      presetn <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h0000_0020)
      stop_test();
   end
endmodule

// >>> tmoc_pin_load.sv
// Load model on the channel pins that measures period and high time of driven pins.
`timescale 1ns/1ps
module tmoc_pin_load (
   // Clock
   input  wire logic             pclk,
   // Channel pins as seen by the load
   input  wire logic [5:0]       pin,
   input  wire logic [5:0]       oe,
   // Figures of the last whole period
   output logic      [5:0][15:0] high_cnt,
   output logic      [5:0][15:0] period
);
   logic [5:0][15:0] run_hi = '0;
   logic [5:0][15:0] run_p = '0;
   logic [5:0]       last = '0;
   // A rising edge on a driven pin closes one period and opens the next.
   always @(posedge pclk) begin
      for (int i = 0; i < 6; i++) begin
         if (oe[i] && pin[i] && !last[i]) begin
            period[i]   <= run_p[i];
            high_cnt[i] <= run_hi[i];
            run_p[i]    <= 16'h0001;
            run_hi[i]   <= 16'h0001;
         end else begin
            run_p[i]  <= run_p[i] + 16'h0001;
            run_hi[i] <= run_hi[i] + {15'h0000, pin[i]};
         end
         last[i] <= pin[i];
      end
   end
endmodule

// >>> tmoc_pkg.sv
// Package of register offsets, field positions and reset values for the compare timer.
package tmoc_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] TIMER_CTRL_OFS   = 8'h00;
   localparam logic [7:0] COUNTER_OFS      = 8'h04;
   localparam logic [7:0] MODULO_OFS       = 8'h08;
   localparam logic [7:0] CH_BASE_OFS      = 8'h10;
   localparam logic [7:0] CH_STRIDE        = 8'h08;
   localparam logic [7:0] CH_VALUE_SUB     = 8'h04;
   localparam int         NUM_CH           = 6;

   // ****************************************
   // Timer status and control fields
   // ****************************************
   localparam int OVF_FLAG_BIT  = 7;
   localparam int OVF_IE_BIT    = 6;
   localparam int STOP_BIT      = 5;
   localparam int RESET_BIT     = 4;
   localparam int PRESC_LSB     = 0;
   localparam int PRESC_W       = 3;

   // ****************************************
   // Channel status and control fields
   // ****************************************
   localparam int CH_FLAG_BIT   = 7;
   localparam int CH_IE_BIT     = 6;
   localparam int BUF_MODE_BIT  = 5;
   localparam int UNBUF_MODE_BIT = 4;
   localparam int ACT_HI_BIT    = 3;
   localparam int ACT_LO_BIT    = 2;
   localparam int TOV_BIT       = 1;
   localparam int FULL_DUTY_BIT = 0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0]  TIMER_CTRL_RST = 8'h20;
   localparam logic [15:0] MODULO_RST     = 16'hffff;
   localparam logic [7:0]  CH_CTRL_RST    = 8'h00;
   localparam logic [15:0] CH_VALUE_RST   = 16'h0000;
endpackage

// >>> tmoc_prescaler.sv
// Prescaler that turns the bus clock into a one-cycle counter tick enable.
`timescale 1ns/1ps
module tmoc_prescaler (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       clear,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   // Tick
   output logic            tick
);
   // Divider that runs with the timer; the tick fires when the low sel bits of the divider are all ones.
   logic [6:0] div_r;
   logic [6:0] mask;

   // Division by 2**sel, sel 0 giving a tick every cycle.
   always_comb begin
      mask = 7'((8'h01 << sel) - 8'h01);
   end

   // Divider counts only while the timer runs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 7'h00;
      end else if (clear) begin
         div_r <= 7'h00;
      end else if (run) begin
         div_r <= div_r + 7'h01;
      end
   end

   assign tick = run && !clear && ((div_r & mask) == mask);
endmodule

// >>> tmoc_timer.sv
// Six-channel compare and PWM timer with APB register access.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module tmoc_timer (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Channel pins
   output logic [5:0]       ch_pin_out,
   output logic [5:0]       ch_pin_oe,
   // Interrupt requests to the CPU
   output logic             overflow_irq,
   output logic [5:0]       channel_irq
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0]       tctrl;
      logic [15:0]      count;
      logic [15:0]      modulo;
      logic [5:0][7:0]  chctl;
      logic [5:0][15:0] chval;
      logic [2:0]       odd_active;   // Per pair: odd value controls output.
      logic [2:0]       odd_pending;  // Per pair: odd value written, takes over at overflow.
      logic [2:0]       even_pending; // Per pair: even value written, takes over at overflow.
      logic [5:0]       pin;
      logic [5:0]       pin_oe;
      logic [31:0]      rdata;
      logic             ready;
      logic             ovf_irq;
      logic [5:0]       ch_irq;
   } tmoc_state_type;

   tmoc_state_type s_r;
   tmoc_state_type s_nxt;

   logic       tick;
   logic       ovf_ev;
   logic [5:0] match;
   logic [5:0] ch_en;
   logic       wr_acc;
   logic       rd_acc;
   logic       addr_ok;
   logic [2:0] ch_idx;
   logic       is_val;
   logic [7:0] ch_off;
   logic [15:0] count_nx;

   // ****************************************
   // Prescaler
   // ****************************************
   // Counter tick at the selected division of the bus clock.
   tmoc_prescaler u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (s_r.tctrl[tmoc_pkg::RESET_BIT]),
      .run     (!s_r.tctrl[tmoc_pkg::STOP_BIT]),
      .sel     (s_r.tctrl[tmoc_pkg::PRESC_LSB +: tmoc_pkg::PRESC_W]),
      .tick    (tick)
   );

   // ****************************************
   // Address decode and compare detection
   // ****************************************
   // Decode an APB access into a timer, modulo or channel register.
   always_comb begin
      wr_acc = psel && penable && pwrite && !s_r.ready;
      rd_acc = psel && penable && !pwrite && !s_r.ready;
      ch_off = paddr - tmoc_pkg::CH_BASE_OFS;
      ch_idx = 3'(ch_off >> 3);
      is_val = (ch_off[2:0] == tmoc_pkg::CH_VALUE_SUB[2:0]);
      addr_ok = (paddr[1:0] == 2'b00) && ((paddr == tmoc_pkg::TIMER_CTRL_OFS) ||
                (paddr == tmoc_pkg::COUNTER_OFS) || (paddr == tmoc_pkg::MODULO_OFS) ||
                ((paddr >= tmoc_pkg::CH_BASE_OFS) &&
                 (ch_off < 8'(tmoc_pkg::NUM_CH) * tmoc_pkg::CH_STRIDE)));
   end

   // Overflow when the counter sits at the modulo value on a tick.
   assign ovf_ev = tick && (s_r.count == s_r.modulo);

   // Value the counter moves to on a tick; a compare acts as the counter reaches it.
   assign count_nx = (s_r.count == s_r.modulo) ? 16'h0000 : s_r.count + 16'h0001;

   // Per-channel enable and equality compare, linked pairs using the active value.
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_cmp
         if (g % 2 == 0) begin : g_even
            logic [15:0] act_val;
            assign act_val = s_r.odd_active[g/2] && s_r.chctl[g][tmoc_pkg::BUF_MODE_BIT] ?
                             s_r.chval[g+1] : s_r.chval[g];
            assign ch_en[g] = s_r.chctl[g][tmoc_pkg::BUF_MODE_BIT] ||
                              s_r.chctl[g][tmoc_pkg::UNBUF_MODE_BIT];
            assign match[g] = tick && ch_en[g] && (count_nx == act_val);
         end else begin : g_odd
            // An odd channel is silent while its even partner links the pair.
            assign ch_en[g] = !s_r.chctl[g-1][tmoc_pkg::BUF_MODE_BIT] &&
                              s_r.chctl[g][tmoc_pkg::UNBUF_MODE_BIT];
            assign match[g] = tick && ch_en[g] && (count_nx == s_r.chval[g]);
         end
      end
   endgenerate

   // ****************************************
   // Next-state logic
   // ****************************************
   // Counter, flags, pin actions, pairing and register access in one pass.
   always_comb begin
      logic [1:0] act;
      logic       tov;
      logic       full;
      s_nxt = s_r;
      act = 2'b00;
      tov = 1'b0;
      full = 1'b0;

      // Counter wraps to zero on the tick after the modulo value.
      if (s_r.tctrl[tmoc_pkg::RESET_BIT]) begin
         s_nxt.count = 16'h0000;
         s_nxt.tctrl[tmoc_pkg::RESET_BIT] = 1'b0;
      end else if (ovf_ev) begin
         s_nxt.count = 16'h0000;
      end else if (tick) begin
         s_nxt.count = s_r.count + 16'h0001;
      end

      // Pair hand-over at overflow: the last written value takes control.
      for (int p = 0; p < 3; p++) begin
         if (!s_r.chctl[2*p][tmoc_pkg::BUF_MODE_BIT]) begin
            s_nxt.odd_active[p] = 1'b0;
            s_nxt.odd_pending[p] = 1'b0;
            s_nxt.even_pending[p] = 1'b0;
         end else if (ovf_ev) begin
            if (s_r.odd_pending[p]) begin
               s_nxt.odd_active[p] = 1'b1;
            end else if (s_r.even_pending[p]) begin
               s_nxt.odd_active[p] = 1'b0;
            end
            s_nxt.odd_pending[p] = 1'b0;
            s_nxt.even_pending[p] = 1'b0;
         end
      end

      // Pin actions and flags per channel; compare wins over overflow toggle.
      for (int c = 0; c < 6; c++) begin
         act  = s_r.chctl[c][tmoc_pkg::ACT_HI_BIT -: 2];
         tov  = s_r.chctl[c][tmoc_pkg::TOV_BIT];
         full = s_r.chctl[c][tmoc_pkg::FULL_DUTY_BIT];
         s_nxt.pin_oe[c] = ch_en[c] && (act != 2'b00);
         if (ch_en[c] && tov && ovf_ev) begin
            s_nxt.pin[c] = ~s_r.pin[c];
         end
         if (match[c]) begin
            s_nxt.chctl[c][tmoc_pkg::CH_FLAG_BIT] = 1'b1;
            unique case (act)
               2'b01:   s_nxt.pin[c] = ~s_r.pin[c];
               2'b10:   s_nxt.pin[c] = 1'b0;
               2'b11:   s_nxt.pin[c] = 1'b1;
               default: s_nxt.pin[c] = s_nxt.pin[c];
            endcase
         end
         // Full duty holds the pin at the level opposite the compare action.
         if (ch_en[c] && tov && full) begin
            s_nxt.pin[c] = (act == 2'b10);
         end
      end

      if (ovf_ev) begin
         s_nxt.tctrl[tmoc_pkg::OVF_FLAG_BIT] = 1'b1;
      end

      // APB access completes in one wait state; writes land at the access edge.
      s_nxt.ready = psel && penable && !s_r.ready;
      s_nxt.rdata = 32'h0000_0000;
      if (wr_acc && addr_ok) begin
         if (paddr == tmoc_pkg::TIMER_CTRL_OFS) begin
            // Flag is cleared by writing zero; a set in the same cycle wins.
            // Bit 3 holds no field and always reads as zero.
            s_nxt.tctrl[tmoc_pkg::OVF_IE_BIT:tmoc_pkg::RESET_BIT] =
               pwdata[tmoc_pkg::OVF_IE_BIT:tmoc_pkg::RESET_BIT];
            s_nxt.tctrl[tmoc_pkg::PRESC_LSB +: tmoc_pkg::PRESC_W] =
               pwdata[tmoc_pkg::PRESC_LSB +: tmoc_pkg::PRESC_W];
            if (!pwdata[tmoc_pkg::OVF_FLAG_BIT] && !ovf_ev) begin
               s_nxt.tctrl[tmoc_pkg::OVF_FLAG_BIT] = 1'b0;
            end
         end else if (paddr == tmoc_pkg::MODULO_OFS) begin
            s_nxt.modulo = pwdata[15:0];
         end else if (paddr == tmoc_pkg::COUNTER_OFS) begin
            s_nxt.count = s_nxt.count;
         end else if (is_val) begin
            s_nxt.chval[ch_idx] = pwdata[15:0];
            if (ch_idx[0]) begin
               s_nxt.odd_pending[ch_idx[2:1]] = 1'b1;
               s_nxt.even_pending[ch_idx[2:1]] = 1'b0;
            end else begin
               s_nxt.even_pending[ch_idx[2:1]] = 1'b1;
               s_nxt.odd_pending[ch_idx[2:1]] = 1'b0;
            end
         end else begin
            s_nxt.chctl[ch_idx][6:0] = pwdata[6:0];
            if (ch_idx[0]) begin
               s_nxt.chctl[ch_idx][tmoc_pkg::BUF_MODE_BIT] = 1'b0;
            end
            if (!pwdata[tmoc_pkg::CH_FLAG_BIT] && !match[ch_idx]) begin
               s_nxt.chctl[ch_idx][tmoc_pkg::CH_FLAG_BIT] = 1'b0;
            end
         end
      end
      if (rd_acc && addr_ok) begin
         if (paddr == tmoc_pkg::TIMER_CTRL_OFS) begin
            s_nxt.rdata = {24'h000000, s_r.tctrl};
         end else if (paddr == tmoc_pkg::COUNTER_OFS) begin
            s_nxt.rdata = {16'h0000, s_r.count};
         end else if (paddr == tmoc_pkg::MODULO_OFS) begin
            s_nxt.rdata = {16'h0000, s_r.modulo};
         end else if (is_val) begin
            s_nxt.rdata = {16'h0000, s_r.chval[ch_idx]};
         end else begin
            s_nxt.rdata = {24'h000000, s_r.chctl[ch_idx]};
         end
      end

      // Interrupt requests follow the enabled flags.
      s_nxt.ovf_irq = s_nxt.tctrl[tmoc_pkg::OVF_FLAG_BIT] &&
                      s_nxt.tctrl[tmoc_pkg::OVF_IE_BIT];
      for (int c = 0; c < 6; c++) begin
         s_nxt.ch_irq[c] = s_nxt.chctl[c][tmoc_pkg::CH_FLAG_BIT] &&
                           s_nxt.chctl[c][tmoc_pkg::CH_IE_BIT] && ch_en[c];
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // All state but the prescaler divider is registered here; reset values are constants.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.tctrl        <= tmoc_pkg::TIMER_CTRL_RST;
         s_r.count        <= 16'h0000;
         s_r.modulo       <= tmoc_pkg::MODULO_RST;
         s_r.chctl        <= {6{tmoc_pkg::CH_CTRL_RST}};
         s_r.chval        <= {6{tmoc_pkg::CH_VALUE_RST}};
         s_r.odd_active   <= 3'h0;
         s_r.odd_pending  <= 3'h0;
         s_r.even_pending <= 3'h0;
         s_r.pin          <= 6'h00;
         s_r.pin_oe       <= 6'h00;
         s_r.rdata        <= 32'h0000_0000;
         s_r.ready        <= 1'b0;
         s_r.ovf_irq      <= 1'b0;
         s_r.ch_irq       <= 6'h00;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Every output but pslverr, tied to zero, is a flip-flop of the state.
   assign prdata       = s_r.rdata;
   assign pready       = s_r.ready;
   assign pslverr      = 1'b0;
   assign ch_pin_out   = s_r.pin;
   assign ch_pin_oe    = s_r.pin_oe;
   assign overflow_irq = s_r.ovf_irq;
   assign channel_irq  = s_r.ch_irq;
endmodule

// >>> tmoc_timer_chk.sv
// Checker of bus timing, flag clearing and pin enables at the timer ports.
`timescale 1ns/1ps
module tmoc_timer_chk (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins and requests
   input wire logic [5:0]  ch_pin_out,
   input wire logic [5:0]  ch_pin_oe,
   input wire logic        overflow_irq,
   input wire logic [5:0]  channel_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // First access cycle, then the answer one cycle later.
   sequence s_acc_first;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      pready && psel && penable;
   endsequence
   // A write was on the bus in one of the last three cycles.
   sequence s_wr_recent;
      $past(psel && pwrite) || $past(psel && pwrite, 2) || $past(psel && pwrite, 3);
   endsequence
   AST_READY_ONE_WAIT: assert property (s_acc_first |=> s_done)
      else $error("ready not one cycle after access start");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   AST_NO_SLVERR: assert property (pready |-> !pslverr)
      else $error("slave error raised");
   AST_UNMAPPED_ZERO: assert property (pready && !pwrite && (paddr[1:0] != 2'b00
      || paddr == 8'h0c) |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_CTRL_WIDTH: assert property (pready && !pwrite && paddr == tmoc_pkg::TIMER_CTRL_OFS
      |-> prdata[31:8] == 24'h00_0000 && !prdata[3])
      else $error("control read has bits beyond its fields");
   AST_OE_BY_WRITE: assert property (!$stable(ch_pin_oe) |-> s_wr_recent)
      else $error("pin enable changed without a write");
   AST_OVF_IRQ_CLEAR: assert property ($fell(overflow_irq) |-> s_wr_recent)
      else $error("overflow request dropped without a write");
   AST_CH_IRQ_CLEAR: assert property (|($past(channel_irq) & ~channel_irq) |-> s_wr_recent)
      else $error("channel request dropped without a write");
endmodule
bind tmoc_timer tmoc_timer_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
   .overflow_irq(overflow_irq), .channel_irq(channel_irq));
